// ==== src/slvic_core.sv ====
`timescale 1ns/1ns

module slvic_core (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // peripheral register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata_reg,
  // internal sources, one-cycle pulses
  input  wire logic [2:0]  timer_irq,
  input  wire logic [1:0]  dma_irq,
  // cpu side
  input  wire logic        cpu_ack,
  output logic             cpu_int_reg,
  output logic [7:0]       vector_reg,
  output logic             vector_valid_reg,
  output logic             slave_mode_reg,
  // pins
  input  wire logic        cpu_irq_input,
  input  wire logic        slave_select,
  output logic             slave_irq_reg,
  output logic             acknowledge_out_pin_b
);

  // =====================================================================
  // pin synchronisers
  logic       irq_meta;
  logic       irq_sync;
  logic       sel_meta;
  logic       sel_sync;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end
    else
    begin
      irq_meta <= cpu_irq_input;
      irq_sync <= irq_meta;
      sel_meta <= slave_select;
      sel_sync <= sel_meta;
    end
  end

  // =====================================================================
  // storage
  localparam int unsigned NSRC = slvic_pkg::NSRC;
  logic [2:0]  rank_reg [NSRC];
  logic [5:0]  mask_reg;
  logic [5:0]  req_reg;
  logic [5:0]  req_next;
  logic [5:0]  svc_reg;
  logic [5:0]  svc_next;
  logic [2:0]  thresh_reg;
  logic [4:0]  vbase_reg;
  logic [15:0] reloc_reg;

  // =====================================================================
  // decode
  logic        wr_ctl;
  logic [2:0]  ctl_idx;
  logic        poll_take;
  logic        peek_read;
  logic        eoi_wr;
  logic        ack_take;
  logic        grant;

  always_comb
  begin
    wr_ctl  = reg_wr;
    ctl_idx = 3'h0;
    unique case (reg_addr)
      slvic_pkg::OFF_CTL_T0: ctl_idx = 3'(slvic_pkg::SRC_T0);
      slvic_pkg::OFF_CTL_D0: ctl_idx = 3'(slvic_pkg::SRC_D0);
      slvic_pkg::OFF_CTL_D1: ctl_idx = 3'(slvic_pkg::SRC_D1);
      slvic_pkg::OFF_CTL_T1: ctl_idx = 3'(slvic_pkg::SRC_T1);
      slvic_pkg::OFF_CTL_T2: ctl_idx = 3'(slvic_pkg::SRC_T2);
      default:               wr_ctl  = 1'b0;
    endcase
  end

  assign poll_take = reg_rd & (reg_addr == slvic_pkg::OFF_POLL);
  assign peek_read = reg_rd & (reg_addr == slvic_pkg::OFF_PEEK);
  assign eoi_wr    = reg_wr & (reg_addr == slvic_pkg::OFF_EOI);
  assign ack_take  = slave_mode_reg & cpu_ack & sel_sync;

  // =====================================================================
  // priority resolution
  logic        svc_any;
  logic [2:0]  svc_min;
  logic        win_hit;
  logic [2:0]  win_idx;
  logic [2:0]  win_rank;
  logic [5:0]  eoi_hits;

  always_comb
  begin
    svc_any  = 1'b0;
    svc_min  = slvic_pkg::RANK_RESET;
    win_hit  = 1'b0;
    win_idx  = 3'h0;
    win_rank = slvic_pkg::RANK_RESET;
    eoi_hits = 6'h00;
    for (int i = 0; i < NSRC; i++)
    begin
      if (svc_reg[i] && (!svc_any || rank_reg[i] < svc_min))
      begin
        svc_any = 1'b1;
        svc_min = rank_reg[i];
      end
      eoi_hits[i] = slvic_pkg::SRC_VALID[i] & (rank_reg[i] == reg_wdata[2:0]);
    end
    // 000 wins; equal levels may nest above an in-service level
    for (int i = 0; i < NSRC; i++)
    begin
      if (slvic_pkg::SRC_VALID[i] && req_reg[i] && !mask_reg[i]
          && rank_reg[i] <= thresh_reg
          && (!svc_any || rank_reg[i] <= svc_min)
          && (!win_hit || rank_reg[i] < win_rank))
      begin
        win_hit  = 1'b1;
        win_idx  = 3'(i);
        win_rank = rank_reg[i];
      end
    end
  end

  assign grant = (ack_take | poll_take) & win_hit;

  // =====================================================================
  // control words and shared mask bits
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rank_reg <= '{default: slvic_pkg::RANK_RESET};
      mask_reg <= {6{slvic_pkg::MASK_RESET}} & slvic_pkg::SRC_VALID;
    end
    else if (wr_ctl)
    begin
      rank_reg[ctl_idx] <= reg_wdata[2:0];
      mask_reg[ctl_idx] <= reg_wdata[slvic_pkg::CTL_MASK_BIT];
    end
    else if (reg_wr && reg_addr == slvic_pkg::OFF_MASK)
      mask_reg <= reg_wdata[5:0] & slvic_pkg::SRC_VALID;
  end

  // =====================================================================
  // threshold, vector base, relocation
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      thresh_reg <= slvic_pkg::THRESH_RESET;
      vbase_reg  <= slvic_pkg::VBASE_RESET;
      reloc_reg  <= slvic_pkg::RELOC_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == slvic_pkg::OFF_THRESH)
        thresh_reg <= reg_wdata[2:0];
      if (reg_addr == slvic_pkg::OFF_VECTOR)
        vbase_reg <= reg_wdata[7:3];
      if (reg_addr == slvic_pkg::OFF_RELOC)
        reloc_reg <= reg_wdata;
    end
  end

  // =====================================================================
  // request flags: source set wins over any clear
  always_comb
  begin
    req_next = req_reg;
    if (reg_wr && reg_addr == slvic_pkg::OFF_REQUEST)
    begin
      req_next = (req_reg & ~slvic_pkg::SRC_DMA)
               | (reg_wdata[5:0] & slvic_pkg::SRC_DMA);
    end
    if (reg_wr && reg_addr == slvic_pkg::OFF_STATUS)
    begin
      req_next[slvic_pkg::SRC_T0] = reg_wdata[0];
      req_next[slvic_pkg::SRC_T1] = reg_wdata[1];
      req_next[slvic_pkg::SRC_T2] = reg_wdata[2];
    end
    if (grant)
      req_next[win_idx] = 1'b0;
    req_next[slvic_pkg::SRC_T0] = req_next[slvic_pkg::SRC_T0] | timer_irq[0];
    req_next[slvic_pkg::SRC_T1] = req_next[slvic_pkg::SRC_T1] | timer_irq[1];
    req_next[slvic_pkg::SRC_T2] = req_next[slvic_pkg::SRC_T2] | timer_irq[2];
    req_next[slvic_pkg::SRC_D0] = req_next[slvic_pkg::SRC_D0] | dma_irq[0];
    req_next[slvic_pkg::SRC_D1] = req_next[slvic_pkg::SRC_D1] | dma_irq[1];
  end

  // =====================================================================
  // in-service flags: acknowledge set wins over end-of-service clear
  always_comb
  begin
    svc_next = svc_reg;
    if (reg_wr && reg_addr == slvic_pkg::OFF_SERVICE)
      svc_next = reg_wdata[5:0] & slvic_pkg::SRC_VALID;
    if (eoi_wr)
      svc_next = svc_next & ~eoi_hits;
    if (grant)
      svc_next[win_idx] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_reg <= 6'h00;
      svc_reg <= 6'h00;
    end
    else
    begin
      req_reg <= req_next;
      svc_reg <= svc_next;
    end
  end

  // =====================================================================
  // register readback, one cycle after the read strobe
  logic [15:0] poll_word;
  logic [15:0] rd_mux;

  assign poll_word = {win_hit, 7'h00, vbase_reg, win_rank};

  always_comb
  begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      slvic_pkg::OFF_VECTOR:  rd_mux = {8'h00, vbase_reg, 3'h0};
      slvic_pkg::OFF_POLL,
      slvic_pkg::OFF_PEEK:    rd_mux = poll_word;
      slvic_pkg::OFF_MASK:    rd_mux = {10'h000, mask_reg};
      slvic_pkg::OFF_THRESH:  rd_mux = {13'h0000, thresh_reg};
      slvic_pkg::OFF_SERVICE: rd_mux = {10'h000, svc_reg};
      slvic_pkg::OFF_REQUEST: rd_mux = {10'h000, req_reg};
      slvic_pkg::OFF_STATUS:  rd_mux = {13'h0000, req_reg[slvic_pkg::SRC_T2],
                                        req_reg[slvic_pkg::SRC_T1],
                                        req_reg[slvic_pkg::SRC_T0]};
      slvic_pkg::OFF_RELOC:   rd_mux = reloc_reg;
      slvic_pkg::OFF_CTL_T0, slvic_pkg::OFF_CTL_D0, slvic_pkg::OFF_CTL_D1,
      slvic_pkg::OFF_CTL_T1, slvic_pkg::OFF_CTL_T2:
        rd_mux = {12'h000, mask_reg[ctl_idx], rank_reg[ctl_idx]};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata_reg <= 16'h0000;
    else if (reg_rd)
      reg_rdata_reg <= rd_mux;
  end

  // =====================================================================
  // mode, request and acknowledge outputs
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slave_mode_reg        <= 1'b0;
      slave_irq_reg         <= 1'b0;
      cpu_int_reg           <= 1'b0;
      acknowledge_out_pin_b <= 1'b1;
      vector_reg            <= 8'h00;
      vector_valid_reg      <= 1'b0;
    end
    else
    begin
      slave_mode_reg        <= reloc_reg[slvic_pkg::RELOC_SLAVE_BIT];
      slave_irq_reg         <= slave_mode_reg & win_hit;
      // slave mode: the master drives the cpu request pin
      cpu_int_reg           <= slave_mode_reg ? irq_sync : win_hit;
      acknowledge_out_pin_b <= ~(slave_mode_reg & cpu_ack);
      vector_valid_reg      <= ack_take & win_hit;
      if (ack_take && win_hit)
        vector_reg <= {vbase_reg, win_rank};
    end
  end

  // =====================================================================
  // checks
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  poll_sets_a:
    assert property (poll_take && win_hit |=> svc_reg[$past(win_idx)])
    else $error("poll read did not set in-service flag");
  peek_quiet_a:
    assert property (peek_read && !ack_take
                     |=> (svc_reg & ~$past(svc_reg)) == 6'h00)
    else $error("poll peek read set an in-service flag");
  present_flag_a:
    assert property (peek_read |=> reg_rdata_reg[15] == $past(win_hit))
    else $error("request-present flag wrong");
  mode_switch_a:
    assert property (reg_wr && reg_addr == slvic_pkg::OFF_RELOC
                     && reg_wdata[14] |=> ##1 slave_mode_reg)
    else $error("slave mode not entered");
  ack_pin_a:
    assert property (slave_mode_reg && cpu_ack |=> !acknowledge_out_pin_b)
    else $error("acknowledge output not driven");
  nest_block_a:
    assert property (win_hit && svc_any |-> win_rank <= svc_min)
    else $error("lower level passed an in-service level");
  vector_form_a:
    assert property (ack_take && win_hit |=> vector_valid_reg
                     && vector_reg == {$past(vbase_reg), $past(win_rank)})
    else $error("vector wrong");
  eoi_clear_a:
    assert property (eoi_wr && !grant |=> (svc_reg & $past(eoi_hits)) == 6'h00)
    else $error("end-of-service did not clear flag");
  mask_block_a:
    assert property (win_hit |-> !mask_reg[win_idx])
    else $error("masked source won");
  thresh_block_a:
    assert property (win_hit |-> win_rank <= thresh_reg)
    else $error("level below threshold won");
  slave_req_a:
    assert property (slave_mode_reg && win_hit |=> slave_irq_reg)
    else $error("slave request not raised");

  poll_grant_c:   cover property (poll_take && win_hit);
  ack_grant_c:    cover property (ack_take && win_hit);
  nested_grant_c: cover property (grant && svc_any);
  eoi_write_c:    cover property (eoi_wr && (svc_reg & eoi_hits) != 6'h00);

endmodule

// ==== src/slvic_pkg.sv ====
package slvic_pkg;

  // =====================================================================
  // register offsets within the peripheral block
  localparam logic [7:0] OFF_VECTOR  = 8'h20;
  localparam logic [7:0] OFF_EOI     = 8'h22;
  localparam logic [7:0] OFF_POLL    = 8'h24;
  localparam logic [7:0] OFF_PEEK    = 8'h26;
  localparam logic [7:0] OFF_MASK    = 8'h28;
  localparam logic [7:0] OFF_THRESH  = 8'h2A;
  localparam logic [7:0] OFF_SERVICE = 8'h2C;
  localparam logic [7:0] OFF_REQUEST = 8'h2E;
  localparam logic [7:0] OFF_STATUS  = 8'h30;
  localparam logic [7:0] OFF_CTL_T0  = 8'h32;
  localparam logic [7:0] OFF_CTL_D0  = 8'h34;
  localparam logic [7:0] OFF_CTL_D1  = 8'h36;
  localparam logic [7:0] OFF_CTL_T1  = 8'h38;
  localparam logic [7:0] OFF_CTL_T2  = 8'h3A;
  localparam logic [7:0] OFF_RELOC   = 8'hFE;

  // =====================================================================
  // source positions in service, request and mask registers
  localparam int unsigned NSRC   = 6;
  localparam int unsigned SRC_T0 = 0;
  localparam int unsigned SRC_D0 = 2;
  localparam int unsigned SRC_D1 = 3;
  localparam int unsigned SRC_T1 = 4;
  localparam int unsigned SRC_T2 = 5;
  localparam logic [5:0]  SRC_VALID = 6'h3D;
  localparam logic [5:0]  SRC_DMA   = 6'h0C;

  // =====================================================================
  // field positions
  localparam int unsigned CTL_MASK_BIT     = 3;
  localparam int unsigned POLL_PRESENT_BIT = 15;
  localparam int unsigned RELOC_SLAVE_BIT  = 14;

  // =====================================================================
  // values after reset
  localparam logic [2:0]  RANK_RESET   = 3'h7;
  localparam logic        MASK_RESET   = 1'h1;
  localparam logic [2:0]  THRESH_RESET = 3'h7;
  localparam logic [4:0]  VBASE_RESET  = 5'h00;
  localparam logic [15:0] RELOC_RESET  = 16'h0000;

endpackage

// ==== verif/slvic_master_model.sv ====
`timescale 1ns/1ns

// =====================================================================
// master controller and cascade decoder seen from the slave pins
module slvic_master_model #(
  parameter int         LAG      = 3,
  parameter logic [2:0] SLAVE_ID = 3'h2
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // slave pins
  input  wire logic slave_irq_reg,
  input  wire logic acknowledge_out_pin_b,
  output logic      cpu_irq_input,
  output logic      slave_select
);
  logic [LAG-1:0] lag_reg;
  logic [1:0]     idle_cnt_reg;
  logic [2:0]     cascade_address_lines;

  // master answers the slave request after a few cycles
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      lag_reg <= '0;
    else
      lag_reg <= {lag_reg[LAG-2:0], slave_irq_reg};

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      cpu_irq_input <= 1'b0;
    else
      cpu_irq_input <= lag_reg[LAG-1] & acknowledge_out_pin_b;

  // idle cascade lines wander but never match this slave
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      idle_cnt_reg <= 2'h0;
    else
      idle_cnt_reg <= idle_cnt_reg + 2'h1;

  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      cascade_address_lines <= SLAVE_ID ^ 3'h4;
    else if (lag_reg[LAG-1])
      cascade_address_lines <= SLAVE_ID;
    else
      cascade_address_lines <= SLAVE_ID ^ {1'b1, idle_cnt_reg};

  assign slave_select = (cascade_address_lines == SLAVE_ID);
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ns

module tb;
  // =====================================================================
  // stimulus and observed signals
  logic        clk_sys   = 1'b0;
  logic        rst_b     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [2:0]  timer_irq = 3'h0;
  logic [1:0]  dma_irq   = 2'h0;
  logic        cpu_ack   = 1'b0;
  logic [15:0] reg_rdata_reg;
  logic        cpu_int_reg;
  logic [7:0]  vector_reg;
  logic        vector_valid_reg;
  logic        slave_mode_reg;
  logic        cpu_irq_input;
  logic        slave_select;
  logic        slave_irq_reg;
  logic        acknowledge_out_pin_b;
  logic [15:0] d;
  int          n_fail = 0;
  int          checks = 0;

  slvic_core i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg), .timer_irq(timer_irq),
    .dma_irq(dma_irq), .cpu_ack(cpu_ack), .cpu_int_reg(cpu_int_reg),
    .vector_reg(vector_reg), .vector_valid_reg(vector_valid_reg),
    .slave_mode_reg(slave_mode_reg), .cpu_irq_input(cpu_irq_input),
    .slave_select(slave_select), .slave_irq_reg(slave_irq_reg),
    .acknowledge_out_pin_b(acknowledge_out_pin_b));

  slvic_master_model #(.LAG(3), .SLAVE_ID(3'h2)) i_master (
    .clk_sys(clk_sys), .rst_b(rst_b), .slave_irq_reg(slave_irq_reg),
    .acknowledge_out_pin_b(acknowledge_out_pin_b),
    .cpu_irq_input(cpu_irq_input), .slave_select(slave_select));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // =====================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata_reg;
  endtask

  task automatic pulse(input logic [2:0] t, input logic [1:0] m);
    @(posedge clk_sys);
    timer_irq <= t;
    dma_irq   <= m;
    @(posedge clk_sys);
    timer_irq <= 3'h0;
    dma_irq   <= 2'h0;
  endtask

  function automatic logic [15:0] poll_word(input logic [2:0] lvl);
    poll_word = {1'b1, 7'h00, 5'h15, lvl};
  endfunction

  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset();
    logic [7:0]  a[8] = '{8'h32, 8'h28, 8'h2A, 8'h2C, 8'h2E, 8'h3C,
                          8'h22, 8'h30};
    logic [15:0] e[8] = '{16'h000F, 16'h003D, 16'h0007, 16'h0000,
                          16'h0000, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++)
    begin
      rd(a[i], d);
      chk("reset read", e[i], d);
    end
    chk("master mode", 16'h0000, {15'h0, slave_mode_reg});
    $display("t_reset done");
  endtask

  task automatic t_setup();
    wr(8'hFE, 16'h4000);
    idle(2);
    chk("slave mode", 16'h0001, {15'h0, slave_mode_reg});
    wr(8'h20, 16'h00A8);
    wr(8'h32, 16'h0003);
    wr(8'h34, 16'h0001);
    wr(8'h38, 16'h0005);
    rd(8'h28, d);
    chk("mask view", 16'h0028, d);
    $display("t_setup done");
  endtask

  task automatic t_peek();
    wr(8'h2E, 16'h0004);
    rd(8'h26, d);
    chk("peek word", poll_word(3'h1), d);
    rd(8'h2C, d);
    chk("peek no service", 16'h0000, d);
    wr(8'h2E, 16'h0000);
    rd(8'h26, d);
    chk("peek empty", 16'h0000, d & 16'h8000);
    $display("t_peek done");
  endtask

  task automatic t_poll();
    pulse(3'h1, 2'h0);
    rd(8'h24, d);
    chk("poll word", poll_word(3'h3), d);
    rd(8'h2C, d);
    chk("poll service", 16'h0001, d);
    rd(8'h2E, d);
    chk("poll request", 16'h0000, d);
    $display("t_poll done");
  endtask

  task automatic t_nest();
    int n;
    pulse(3'h2, 2'h0);
    idle(3);
    chk("lower blocked", 16'h0000, {15'h0, slave_irq_reg});
    pulse(3'h0, 2'h1);
    idle(1);
    chk("higher nests", 16'h0001, {15'h0, slave_irq_reg});
    n = 0;
    while (cpu_int_reg !== 1'b1 && n < 30)
    begin
      idle(1);
      n++;
    end
    chk("cpu irq", 16'h0001, {15'h0, cpu_int_reg});
    @(posedge clk_sys);
    cpu_ack <= 1'b1;
    @(posedge clk_sys);
    cpu_ack <= 1'b0;
    #1;
    chk("vector valid", 16'h0001, {15'h0, vector_valid_reg});
    chk("vector", 16'h00A9, {8'h00, vector_reg});
    chk("ack pin", 16'h0000, {15'h0, acknowledge_out_pin_b});
    rd(8'h2C, d);
    chk("nested service", 16'h0005, d);
    $display("t_nest done");
  endtask

  task automatic t_eoi();
    wr(8'h22, 16'h0001);
    rd(8'h2C, d);
    chk("eoi one", 16'h0001, d);
    wr(8'h22, 16'h0003);
    rd(8'h2C, d);
    chk("eoi three", 16'h0000, d);
    idle(2);
    chk("lower released", 16'h0001, {15'h0, slave_irq_reg});
    $display("t_eoi done");
  endtask

  task automatic t_mask();
    wr(8'h28, 16'h0038);
    rd(8'h38, d);
    chk("ctl mask view", 16'h000D, d);
    idle(2);
    chk("masked", 16'h0000, {15'h0, slave_irq_reg});
    wr(8'h38, 16'h0005);
    wr(8'h2A, 16'h0004);
    idle(2);
    chk("threshold four", 16'h0000, {15'h0, slave_irq_reg});
    wr(8'h2A, 16'h0007);
    idle(2);
    chk("threshold seven", 16'h0001, {15'h0, slave_irq_reg});
    $display("t_mask done");
  endtask

  task automatic t_regs();
    wr(8'h2C, 16'h003F);
    rd(8'h2C, d);
    chk("service write", 16'h003D, d);
    idle(2);
    chk("service blocks", 16'h0000, {15'h0, slave_irq_reg});
    wr(8'h2C, 16'h0000);
    wr(8'h30, 16'h8005);
    rd(8'h30, d);
    chk("status", 16'h0005, d);
    wr(8'h2E, 16'h003F);
    rd(8'h2E, d);
    chk("request write", 16'h002D, d);
    rd(8'h26, d);
    chk("peek order", poll_word(3'h1), d);
    rd(8'h20, d);
    chk("vector read", 16'h00A8, d);
    $display("t_regs done");
  endtask

  // =====================================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_setup();
    t_peek();
    t_poll();
    t_nest();
    t_eoi();
    t_mask();
    t_regs();
    close_out();
  end

  initial
  begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule
